// >>> shared/asp_pkg.sv
// Package of register map, field layout and encodings for the async serial port
package asp_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ASP_OFS_CTRL = 8'h00;
  localparam logic [7:0] ASP_OFS_DIV = 8'h04;
  localparam logic [7:0] ASP_OFS_TXDATA = 8'h08;
  localparam logic [7:0] ASP_OFS_RXDATA = 8'h0c;
  localparam logic [7:0] ASP_OFS_STATUS = 8'h10;
  localparam logic [7:0] ASP_OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] ASP_OFS_IRQ_MASK = 8'h18;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int ASP_CTRL_PAR_LSB = 0;
  localparam int ASP_CTRL_TWO_STOP = 2;
  localparam int ASP_CTRL_REDUCED = 3;
  localparam int ASP_CTRL_RED_DIV8 = 4;
  localparam int ASP_CTRL_SRC_LSB = 5;
  localparam int ASP_CTRL_RED_SRC = 7;
  localparam int ASP_CTRL_W = 8;
  localparam logic [7:0] ASP_CTRL_RST = 8'h00;
  localparam logic [11:0] ASP_DIV_RST = 12'h007;
  // ----------------------------------------
  // Status and interrupt bits
  // ----------------------------------------
  localparam int ASP_ST_TX_BUSY = 0;
  localparam int ASP_ST_RX_FULL = 1;
  localparam int ASP_ST_RX_BUSY = 2;
  localparam int ASP_IRQ_TX_DONE = 0;
  localparam int ASP_IRQ_RX_DONE = 1;
  localparam int ASP_IRQ_FRAME = 2;
  localparam int ASP_IRQ_PARITY = 3;
  localparam int ASP_IRQ_W = 4;
  localparam logic [3:0] ASP_IRQ_MASK_RST = 4'h0;
  // ----------------------------------------
  // Encodings and bit-time counts
  // ----------------------------------------
  localparam logic [1:0] ASP_PAR_NONE = 2'h0;
  localparam logic [1:0] ASP_PAR_EVEN = 2'h1;
  localparam logic [1:0] ASP_PAR_ODD = 2'h2;
  localparam logic [1:0] ASP_SRC_SYS = 2'h0;
  localparam logic [1:0] ASP_SRC_LSC = 2'h1;
  localparam logic [1:0] ASP_SRC_MCC = 2'h2;
  localparam logic [1:0] ASP_SRC_PIN = 2'h3;
  localparam logic [12:0] ASP_MIN_PERIOD = 13'h0008;
  localparam logic [12:0] ASP_MAX_PERIOD = 13'h1000;
  localparam logic [12:0] ASP_RED_SHORT = 13'h0004;
  localparam logic [12:0] ASP_RED_LONG = 13'h0008;
  localparam logic [2:0] ASP_LAST_BIT = 3'h7;

  typedef enum logic [2:0] {ASP_IDLE, ASP_START, ASP_DATA, ASP_PAR, ASP_STOP} asp_state_t;

  function automatic logic asp_par_bit(input logic [7:0] d, input logic [1:0] mode);
    asp_par_bit = (mode == ASP_PAR_ODD) ? ~(^d) : (^d);
  endfunction
endpackage

// >>> rtl/asp_src_tick.sv
// Baud source selection and edge detection, one enable per source period
`timescale 1ns/1ps
module asp_src_tick import asp_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Selection
  input wire logic reduced,
  input wire logic red_src_timer,
  input wire logic [1:0] src_sel,
  // Source levels and pulses
  input wire logic low_speed_crystal_clock,
  input wire logic main_ceramic_clock,
  input wire logic port_baud_pin,
  input wire logic reduced_port_baud_pin,
  input wire logic fourth_general_timer_tick,
  // Output enable
  output logic src_tick
);
  logic lvl;
  logic prev_ff;
  logic nxt_prev;

  always_comb begin
    case (src_sel)
      ASP_SRC_LSC: lvl = low_speed_crystal_clock;
      ASP_SRC_MCC: lvl = main_ceramic_clock;
      ASP_SRC_PIN: lvl = port_baud_pin;
      default: lvl = 1'b0;
    endcase
    if (reduced) begin
      lvl = reduced_port_baud_pin;
    end
    nxt_prev = lvl;
    // Each rising edge of a slow source counts as one source period
    if (reduced) begin
      src_tick = red_src_timer ? fourth_general_timer_tick : (lvl & ~prev_ff);
    end else if (src_sel == ASP_SRC_SYS) begin
      src_tick = 1'b1;
    end else begin
      src_tick = lvl & ~prev_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
    end
  end
endmodule

// >>> rtl/asp_top.sv
// Async serial port: AHB-Lite registers, transmitter, receiver, interrupts
`timescale 1ns/1ps
module asp_top import asp_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial line
  output logic txd,
  input wire logic rxd,
  // Baud sources
  input wire logic low_speed_crystal_clock,
  input wire logic main_ceramic_clock,
  input wire logic port_baud_pin,
  input wire logic reduced_port_baud_pin,
  input wire logic fourth_general_timer_tick,
  // Interrupt and wakeup
  output logic irq,
  output logic hold_release
);
  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic wr_ff, nxt_wr;
  logic [7:0] addr_ff, nxt_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [11:0] div_ff, nxt_div;
  logic [3:0] mask_ff, nxt_mask;
  logic [3:0] stat_ff, nxt_stat;
  logic [7:0] rxdata_ff, nxt_rxdata;
  logic rx_full_ff, nxt_rx_full;
  logic addr_ph, wr_ph, tx_load;
  logic [3:0] events;
  asp_state_t tx_st_ff, nxt_tx_st, rx_st_ff, nxt_rx_st;

  assign addr_ph = hsel & htrans[1] & hready;
  assign wr_ph = wr_ff & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [7:0] c, input logic [11:0] dv,
                                         input logic [7:0] rd, input logic [2:0] st, input logic [3:0] is,
                                         input logic [3:0] im);
    case (a)
      ASP_OFS_CTRL: rd_mux = {24'h000000, c};
      ASP_OFS_DIV: rd_mux = {20'h00000, dv};
      ASP_OFS_RXDATA: rd_mux = {24'h000000, rd};
      ASP_OFS_STATUS: rd_mux = {29'h00000000, st};
      ASP_OFS_IRQ_STAT: rd_mux = {28'h0000000, is};
      ASP_OFS_IRQ_MASK: rd_mux = {28'h0000000, im};
      default: rd_mux = 32'h00000000;
    endcase
  endfunction

  wire [2:0] status_w = {rx_st_ff != ASP_IDLE, rx_full_ff, tx_st_ff != ASP_IDLE};

  always_comb begin
    nxt_wr = addr_ph & hwrite;
    nxt_addr = addr_ph ? {haddr[7:2], 2'b00} : addr_ff;
    nxt_hrdata = hrdata_ff;
    if (addr_ph & ~hwrite) begin
      nxt_hrdata = rd_mux({haddr[7:2], 2'b00}, ctrl_ff, div_ff, rxdata_ff, status_w, stat_ff, mask_ff);
    end
    nxt_ctrl = ctrl_ff;
    nxt_div = div_ff;
    nxt_mask = mask_ff;
    if (wr_ph && addr_ff == ASP_OFS_CTRL) begin
      nxt_ctrl = hwdata[7:0];
    end
    if (wr_ph && addr_ff == ASP_OFS_DIV) begin
      nxt_div = hwdata[11:0];
    end
    if (wr_ph && addr_ff == ASP_OFS_IRQ_MASK) begin
      nxt_mask = hwdata[3:0];
    end
    // Hardware set wins over a simultaneous write-one clear
    nxt_stat = stat_ff;
    if (wr_ph && addr_ff == ASP_OFS_IRQ_STAT) begin
      nxt_stat = stat_ff & ~hwdata[3:0];
    end
    nxt_stat = nxt_stat | events;
  end

  assign tx_load = wr_ph && addr_ff == ASP_OFS_TXDATA && tx_st_ff == ASP_IDLE;
  assign irq = |(stat_ff & mask_ff);
  assign hold_release = irq;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      addr_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
      ctrl_ff <= ASP_CTRL_RST;
      div_ff <= ASP_DIV_RST;
      mask_ff <= ASP_IRQ_MASK_RST;
      stat_ff <= 4'h0;
    end else begin
      wr_ff <= nxt_wr;
      addr_ff <= nxt_addr;
      hrdata_ff <= nxt_hrdata;
      ctrl_ff <= nxt_ctrl;
      div_ff <= nxt_div;
      mask_ff <= nxt_mask;
      stat_ff <= nxt_stat;
    end
  end

  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  logic [1:0] par_mode;
  logic reduced, two_stop, src_tick;
  logic [12:0] period, half;
  assign par_mode = ctrl_ff[ASP_CTRL_PAR_LSB +: 2];
  assign reduced = ctrl_ff[ASP_CTRL_REDUCED];
  assign two_stop = ctrl_ff[ASP_CTRL_TWO_STOP] & ~reduced;

  always_comb begin
    if (reduced) begin
      period = ctrl_ff[ASP_CTRL_RED_DIV8] ? ASP_RED_LONG : ASP_RED_SHORT;
    end else if ({1'b0, div_ff} + 13'h0001 < ASP_MIN_PERIOD) begin
      period = ASP_MIN_PERIOD;
    end else begin
      period = {1'b0, div_ff} + 13'h0001;
    end
    half = period >> 1;
  end

  asp_src_tick u_src (
    .hclk(hclk),
    .hresetn(hresetn),
    .reduced(reduced),
    .red_src_timer(ctrl_ff[ASP_CTRL_RED_SRC]),
    .src_sel(ctrl_ff[ASP_CTRL_SRC_LSB +: 2]),
    .low_speed_crystal_clock(low_speed_crystal_clock),
    .main_ceramic_clock(main_ceramic_clock),
    .port_baud_pin(port_baud_pin),
    .reduced_port_baud_pin(reduced_port_baud_pin),
    .fourth_general_timer_tick(fourth_general_timer_tick),
    .src_tick(src_tick)
  );

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  logic [12:0] tx_cnt_ff, nxt_tx_cnt;
  logic [2:0] tx_bit_ff, nxt_tx_bit;
  logic [7:0] tx_sh_ff, nxt_tx_sh;
  logic txd_ff, nxt_txd, tx_par_ff, nxt_tx_par, tx_done;
  assign txd = txd_ff;

  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_txd = txd_ff;
    nxt_tx_par = tx_par_ff;
    tx_done = 1'b0;
    if (tx_st_ff == ASP_IDLE) begin
      nxt_txd = 1'b1;
      if (tx_load) begin
        nxt_tx_sh = hwdata[7:0];
        nxt_tx_par = asp_par_bit(hwdata[7:0], par_mode);
        nxt_tx_st = ASP_START;
        nxt_txd = 1'b0;
        nxt_tx_cnt = 13'h0000;
      end
    end else if (src_tick) begin
      nxt_tx_cnt = tx_cnt_ff + 13'h0001;
      if (tx_cnt_ff == period - 13'h0001) begin
        nxt_tx_cnt = 13'h0000;
        case (tx_st_ff)
          ASP_START: begin
            nxt_tx_st = ASP_DATA;
            nxt_tx_bit = 3'h0;
            nxt_txd = tx_sh_ff[0];
          end
          ASP_DATA: begin
            nxt_tx_sh = tx_sh_ff >> 1;
            nxt_tx_bit = tx_bit_ff + 3'h1;
            nxt_txd = tx_sh_ff[1];
            if (tx_bit_ff == ASP_LAST_BIT) begin
              nxt_tx_bit = 3'h0;
              nxt_tx_st = (par_mode == ASP_PAR_NONE) ? ASP_STOP : ASP_PAR;
              nxt_txd = (par_mode == ASP_PAR_NONE) ? 1'b1 : tx_par_ff;
            end
          end
          ASP_PAR: begin
            nxt_tx_st = ASP_STOP;
            nxt_txd = 1'b1;
          end
          ASP_STOP: begin
            if (two_stop && tx_bit_ff == 3'h0) begin
              nxt_tx_bit = 3'h1;
            end else begin
              nxt_tx_st = ASP_IDLE;
              tx_done = 1'b1;
            end
          end
          default: nxt_tx_st = ASP_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st_ff <= ASP_IDLE;
      tx_cnt_ff <= 13'h0000;
      tx_bit_ff <= 3'h0;
      tx_sh_ff <= 8'h00;
      txd_ff <= 1'b1;
      tx_par_ff <= 1'b0;
    end else begin
      tx_st_ff <= nxt_tx_st;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_bit_ff <= nxt_tx_bit;
      tx_sh_ff <= nxt_tx_sh;
      txd_ff <= nxt_txd;
      tx_par_ff <= nxt_tx_par;
    end
  end

  // ----------------------------------------
  // Receiver, independent of the transmitter
  // ----------------------------------------
  logic [12:0] rx_cnt_ff, nxt_rx_cnt;
  logic [2:0] rx_bit_ff, nxt_rx_bit;
  logic [7:0] rx_sh_ff, nxt_rx_sh;
  logic rx_perr_ff, nxt_rx_perr, rx_done, rx_ferr, rx_rd;
  assign rx_rd = addr_ph & ~hwrite & ({haddr[7:2], 2'b00} == ASP_OFS_RXDATA);

  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_perr = rx_perr_ff;
    nxt_rxdata = rxdata_ff;
    nxt_rx_full = rx_full_ff & ~rx_rd;
    rx_done = 1'b0;
    rx_ferr = 1'b0;
    if (rx_st_ff == ASP_IDLE) begin
      if (!rxd) begin
        nxt_rx_st = ASP_START;
        nxt_rx_cnt = 13'h0000;
        nxt_rx_perr = 1'b0;
      end
    end else if (src_tick) begin
      nxt_rx_cnt = rx_cnt_ff + 13'h0001;
      // Start bit is checked at its middle, so every later sample is mid-bit
      if (rx_st_ff == ASP_START) begin
        if (rx_cnt_ff == half - 13'h0001) begin
          nxt_rx_cnt = 13'h0000;
          nxt_rx_bit = 3'h0;
          nxt_rx_st = rxd ? ASP_IDLE : ASP_DATA;
        end
      end else if (rx_cnt_ff == period - 13'h0001) begin
        nxt_rx_cnt = 13'h0000;
        case (rx_st_ff)
          ASP_DATA: begin
            nxt_rx_sh = {rxd, rx_sh_ff[7:1]};
            nxt_rx_bit = rx_bit_ff + 3'h1;
            if (rx_bit_ff == ASP_LAST_BIT) begin
              nxt_rx_st = (par_mode == ASP_PAR_NONE) ? ASP_STOP : ASP_PAR;
            end
          end
          ASP_PAR: begin
            nxt_rx_perr = rxd != asp_par_bit(rx_sh_ff, par_mode);
            nxt_rx_st = ASP_STOP;
          end
          ASP_STOP: begin
            // Only the first stop bit is checked; a second one is idle line
            rx_done = 1'b1;
            rx_ferr = ~rxd;
            nxt_rxdata = rx_sh_ff;
            nxt_rx_full = 1'b1;
            nxt_rx_st = ASP_IDLE;
          end
          default: nxt_rx_st = ASP_IDLE;
        endcase
      end
    end
  end

  assign events = {rx_done & rx_perr_ff, rx_ferr, rx_done, tx_done};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_ff <= ASP_IDLE;
      rx_cnt_ff <= 13'h0000;
      rx_bit_ff <= 3'h0;
      rx_sh_ff <= 8'h00;
      rx_perr_ff <= 1'b0;
      rxdata_ff <= 8'h00;
      rx_full_ff <= 1'b0;
    end else begin
      rx_st_ff <= nxt_rx_st;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_bit_ff <= nxt_rx_bit;
      rx_sh_ff <= nxt_rx_sh;
      rx_perr_ff <= nxt_rx_perr;
      rxdata_ff <= nxt_rxdata;
      rx_full_ff <= nxt_rx_full;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_tx_start_low: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_load |=> (tx_st_ff == ASP_START && !txd)) else $error("start bit not low");
  a_tx_lsb_first: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_st_ff == ASP_START && nxt_tx_st == ASP_DATA) |=> (txd == $past(tx_sh_ff[0]))) else $error("lsb not first");
  a_tx_stop_high: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_st_ff == ASP_STOP || tx_st_ff == ASP_IDLE) |-> txd) else $error("stop bit not high");
  a_period_range: assert property (@(posedge hclk) disable iff (!hresetn)
    !reduced |-> (period >= ASP_MIN_PERIOD && period <= ASP_MAX_PERIOD)) else $error("bit time out of range");
  a_reduced_period: assert property (@(posedge hclk) disable iff (!hresetn)
    reduced |-> (period == ASP_RED_SHORT || period == ASP_RED_LONG)) else $error("reduced bit time bad");
  a_reduced_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    (reduced && tx_done) |-> (tx_bit_ff == 3'h0)) else $error("reduced port sent two stops");
  a_frame_err: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_st_ff == ASP_STOP && src_tick && rx_cnt_ff == period - 13'h0001 && !rxd)
    |=> stat_ff[ASP_IRQ_FRAME]) else $error("framing error lost");
  a_irq_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    (events[ASP_IRQ_RX_DONE] && mask_ff[ASP_IRQ_RX_DONE]) |=> (irq && hold_release)) else $error("no wake on rx");
endmodule

// >>> testbench/asp_peer.sv
// Remote serial transceiver model facing the port's serial line
`timescale 1ns/1ps
module asp_peer (
  // Clock
  input wire logic hclk,
  // Serial line
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;

  // ------
  // Sender
  // ------
  // A bad stop is held low only three quarters of a bit, so the start seen after it fails the mid-bit check
  task automatic send(input int cpb, input logic [7:0] d, input logic [1:0] par, input logic bs, input logic bp);
    @(posedge hclk) rxd <= 1'b0;
    repeat (cpb) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      rxd <= d[i];
      repeat (cpb) @(posedge hclk);
    end
    if (par != 2'h0) begin
      rxd <= (^d) ^ (par == 2'h2) ^ bp;
      repeat (cpb) @(posedge hclk);
    end
    rxd <= ~bs;
    repeat (bs ? cpb * 3 / 4 : cpb) @(posedge hclk);
    rxd <= 1'b1;
  endtask

  task automatic glitch(input int n);
    @(posedge hclk) rxd <= 1'b0;
    repeat (n) @(posedge hclk);
    rxd <= 1'b1;
  endtask

  // --------
  // Receiver
  // --------
  task automatic recv(input int cpb, input logic [1:0] par, input int ns, output logic [7:0] d, output logic pb,
    output int st);
    int n;
    n = 0;
    st = 0;
    d = 8'h00;
    pb = 1'b0;
    while (txd !== 1'b0 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 400) st = 1;
    else begin
      repeat (cpb / 2) @(posedge hclk);
      if (txd !== 1'b0) st = 2;
      for (int i = 0; i < 8; i++) begin
        repeat (cpb) @(posedge hclk);
        d[i] = txd;
      end
      if (par != 2'h0) begin
        repeat (cpb) @(posedge hclk);
        pb = txd;
      end
      for (int i = 0; i < ns; i++) begin
        repeat (cpb) @(posedge hclk);
        if (txd !== 1'b1) st = 2;
      end
    end
  endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench of the async serial port
`timescale 1ns/1ps
module tb import asp_pkg::*;;
  typedef struct {logic [7:0] c; logic [11:0] dv; logic [7:0] tx; logic [7:0] rx;} asp_row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, txd, irq, hold_release;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] ph = 4'h0;
  logic [1:0] c3 = 2'h0;
  wire logic rxd;
  int n_mismatch = 0;
  int compares = 0;
  asp_row_t rows [11] = '{'{8'h00, 12'h007, 8'ha5, 8'h3c}, '{8'h01, 12'h009, 8'h81, 8'h7e},
    '{8'h06, 12'h00f, 8'h01, 8'hfe}, '{8'h02, 12'h003, 8'h00, 8'hff}, '{8'h00, 12'hfff, 8'h5a, 8'hc3},
    '{8'h21, 12'h007, 8'h12, 8'h34}, '{8'h42, 12'h007, 8'h56, 8'h78}, '{8'h64, 12'h007, 8'h9a, 8'hbc},
    '{8'h08, 12'h000, 8'hde, 8'had}, '{8'h9c, 12'h000, 8'hbe, 8'hef}, '{8'h19, 12'h000, 8'h6e, 8'h91}};

  // Source clocks: period 4 for low speed, 8 for the port pin, 2 for the others, timer tick every 3
  // Pin and main clock differ so a wrong source selection shows up as a bad frame
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) ph <= ph + 4'h1;
  always @(posedge hclk) c3 <= (c3 == 2'h2) ? 2'h0 : c3 + 2'h1;

  asp_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .txd(txd), .rxd(rxd), .low_speed_crystal_clock(ph[1]), .main_ceramic_clock(ph[0]), .port_baud_pin(ph[2]),
    .reduced_port_baud_pin(ph[0]), .fourth_general_timer_tick(c3 == 2'h0), .irq(irq), .hold_release(hold_release));
  asp_peer peer (.hclk(hclk), .txd(txd), .rxd(rxd));

  // ---------
  // Bus tasks
  // ---------
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      complete_run();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
    // Registers change at the landing edge; compare only once they have settled
    #1;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, e, r);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // Cycles per bit as seen at hclk for a given setting
  function automatic int cpb_of(input logic [7:0] c, input logic [11:0] dv);
    int p, m;
    if (c[ASP_CTRL_REDUCED]) begin
      p = c[4] ? 8 : 4;
      m = c[7] ? 3 : 2;
    end else begin
      p = (dv < 12'h007) ? 8 : int'(dv) + 1;
      m = (c[6:5] == ASP_SRC_SYS) ? 1 : (c[6:5] == ASP_SRC_LSC) ? 4 : (c[6:5] == ASP_SRC_PIN) ? 8 : 2;
    end
    return p * m;
  endfunction

  // One frame each way at once, then status, data and events
  task automatic frame(input logic [7:0] c, input logic [11:0] dv, input logic [7:0] tx, input logic [7:0] rx,
    input logic bs, input logic bp, input logic [3:0] ev);
    int cp, ns, st;
    logic [7:0] got;
    logic pb;
    cp = cpb_of(c, dv);
    ns = (c[2] && !c[3]) ? 2 : 1;
    wr(ASP_OFS_CTRL, {24'h0, c});
    wr(ASP_OFS_DIV, {20'h0, dv});
    wr(ASP_OFS_IRQ_MASK, 32'hf);
    fork
      peer.recv(cp, c[1:0], ns, got, pb, st);
      wr(ASP_OFS_TXDATA, {24'h0, tx});
      peer.send(cp, rx, c[1:0], bs, bp);
    join
    chk("tx frame", 0, st);
    if (st == 1) complete_run();
    chk("tx data", {24'h0, tx}, {24'h0, got});
    if (c[1:0] != ASP_PAR_NONE) chk("tx parity", (^tx) ^ (c[1:0] == ASP_PAR_ODD), pb);
    repeat (cp) @(posedge hclk);
    rchk("status", ASP_OFS_STATUS, 32'h2);
    rchk("rx data", ASP_OFS_RXDATA, {24'h0, rx});
    rchk("events", ASP_OFS_IRQ_STAT, {28'h0, ev});
    chk("irq", 1, irq);
    chk("wakeup", 1, hold_release);
    wr(ASP_OFS_IRQ_STAT, 32'hf);
    chk("irq clear", 0, irq);
  endtask

  // ---------
  // Sequence
  // ---------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) frame(rows[i].c, rows[i].dv, rows[i].tx, rows[i].rx, 1'b0, 1'b0, 4'h3);
    frame(8'h00, 12'h007, 8'h11, 8'h22, 1'b1, 1'b0, 4'h7);
    frame(8'h01, 12'h007, 8'h33, 8'h44, 1'b0, 1'b1, 4'hb);
    peer.glitch(2);
    repeat (20) @(posedge hclk);
    rchk("glitch", ASP_OFS_IRQ_STAT, 32'h0);
    wr(ASP_OFS_CTRL, 32'h0);
    wr(ASP_OFS_IRQ_MASK, 32'h0);
    peer.send(8, 8'h55, 2'h0, 1'b0, 1'b0);
    rchk("masked event", ASP_OFS_IRQ_STAT, 32'h2);
    chk("masked irq", 0, irq);
    wr(ASP_OFS_IRQ_MASK, 32'h2);
    chk("unmasked irq", 1, irq);
    wr(ASP_OFS_IRQ_STAT, 32'h2);
    chk("cleared irq", 0, irq);
    wr(8'h1c, 32'hff);
    rchk("unmapped", 8'h1c, 32'h0);
    wr(ASP_OFS_TXDATA, 32'h0f);
    @(posedge hclk) hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("reset txd", 1, txd);
    chk("reset hrdata", 32'h0, hrdata);
    hresetn <= 1'b1;
    rchk("reset ctrl", ASP_OFS_CTRL, {24'h0, ASP_CTRL_RST});
    rchk("reset div", ASP_OFS_DIV, {20'h0, ASP_DIV_RST});
    rchk("reset mask", ASP_OFS_IRQ_MASK, 32'h0);
    rchk("reset status", ASP_OFS_STATUS, 32'h0);
    complete_run();
  end
endmodule
